// [rtl/low_power_mode_controller.sv]
// Purpose: low-power mode sequencing, halt wake-up and main clock switching
// Assumes: pclk is the selected main clock; halt request writes come over apb
// Notes:   cpu, watchdog and peripheral clocks are gated through enable outputs
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int N_IRQ = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic [N_IRQ-1:0] irq_event,
  input  wire logic             wdt_irq,
  input  wire logic [7:0]       tbt_sources,
  input  wire logic [PC_W-1:0]  entry_pc,
  output logic      [PC_W-1:0]  resume_pc,
  output logic                  cpu_clk_en,
  output logic                  wdt_clk_en,
  output logic                  periph_clk_en,
  output logic                  tbt_clk_en,
  output logic                  hold_state,
  output logic                  vector_req,
  output logic [N_IRQ-1:0]      vector_src,
  output logic                  hf_osc_on,
  output logic                  lf_osc_on,
  output logic                  main_clk_low,
  output logic                  sys_reset_req
);

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  halt_state_t      state_reg;
  logic             hf_en_reg;
  logic             lf_en_reg;
  logic             clk_sel_reg;
  logic             cpu_halt_reg;
  logic             tg_halt_reg;
  logic             tbt_en_reg;
  logic [2:0]       tbt_sel_reg;
  logic             gie_reg;
  logic [N_IRQ-1:0] ie_reg;
  logic [N_IRQ-1:0] il_reg;
  logic [PC_W-1:0]  pc_reg;
  logic             vec_reg;
  logic [N_IRQ-1:0] vsrc_reg;
  logic             rst_req_reg;
  logic [7:0]       tbt_s1;
  logic [7:0]       tbt_s2;
  logic             tbt_prev;
  logic [N_IRQ-1:0] irq_s1;
  logic [N_IRQ-1:0] irq_s2;
  logic             wdt_s1;
  logic             wdt_s2;

  logic             wr;
  logic             tbt_fall;
  logic [N_IRQ-1:0] wake_src;
  logic             product;
  logic [31:0]      rdata_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign wr = psel && penable && pwrite && clk_en;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ---------------------------------------------------------------
  // input synchronisers and time base edge
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbt_s1   <= 8'h00;
      tbt_s2   <= 8'h00;
      tbt_prev <= 1'b0;
      irq_s1   <= '0;
      irq_s2   <= '0;
      wdt_s1   <= 1'b0;
      wdt_s2   <= 1'b0;
    end else if (clk_en) begin
      tbt_s1   <= tbt_sources;
      tbt_s2   <= tbt_s1;
      tbt_prev <= tbt_s2[tbt_sel_reg];
      irq_s1   <= irq_event;
      irq_s2   <= irq_s1;
      wdt_s1   <= wdt_irq;
      wdt_s2   <= wdt_s1;
    end
  end

  // edge seen regardless of the counter phase
  assign tbt_fall = tbt_prev && !tbt_s2[tbt_sel_reg];
  assign wake_src = ie_reg & (il_reg | irq_s2);
  assign product  = gie_reg && ie_reg[TBT_IRQ_BIT] && tbt_en_reg;

  // ---------------------------------------------------------------
  // halt state machine
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_RUN;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_RUN: begin
          if (wr && hit(paddr, SYSTEM_CONTROL_TWO_OFF) && !wdt_s2) begin
            if (pwdata[CPU_HALT_BIT]) begin
              state_reg <= ST_CPU_HALT;
            end else if (pwdata[TG_HALT_BIT]) begin
              state_reg <= ST_TG_HALT;
            end
          end
        end
        ST_CPU_HALT: begin
          if (|wake_src) begin
            state_reg <= ST_RUN;
          end
        end
        ST_TG_HALT: begin
          if (tbt_fall) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // system control bits
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hf_en_reg    <= HF_OSC_EN_RST;
      lf_en_reg    <= LF_OSC_EN_RST;
      clk_sel_reg  <= CLK_SEL_RST;
      cpu_halt_reg <= 1'b0;
      tg_halt_reg  <= 1'b0;
    end else if (clk_en) begin
      if (wr && hit(paddr, SYSTEM_CONTROL_TWO_OFF) && state_reg == ST_RUN) begin
        hf_en_reg    <= pwdata[HF_OSC_EN_BIT];
        lf_en_reg    <= pwdata[LF_OSC_EN_BIT];
        clk_sel_reg  <= pwdata[CLK_SEL_BIT];
        cpu_halt_reg <= pwdata[CPU_HALT_BIT] && !wdt_s2;
        tg_halt_reg  <= pwdata[TG_HALT_BIT] && !pwdata[CPU_HALT_BIT] && !wdt_s2;
      end
      if (state_reg == ST_CPU_HALT && |wake_src) begin
        cpu_halt_reg <= 1'b0;
      end
      if (state_reg == ST_TG_HALT && tbt_fall) begin
        tg_halt_reg <= 1'b0;
      end
    end
  end

  // illegal oscillator combination asks for a system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_req_reg <= 1'b0;
    end else if (clk_en) begin
      rst_req_reg <= (!hf_en_reg && !lf_en_reg) || (!hf_en_reg && !clk_sel_reg) ||
                     (!lf_en_reg && clk_sel_reg);
    end
  end

  // ---------------------------------------------------------------
  // time base control and interrupt flags
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbt_en_reg  <= 1'b0;
      tbt_sel_reg <= TBT_SEL_RST;
      gie_reg     <= 1'b0;
      ie_reg      <= '0;
    end else if (clk_en) begin
      if (wr && hit(paddr, TIME_BASE_CONTROL_OFF)) begin
        tbt_en_reg  <= pwdata[TBT_EN_BIT];
        tbt_sel_reg <= pwdata[2:0];
      end
      if (wr && hit(paddr, IRQ_ENABLE_OFF)) begin
        gie_reg <= pwdata[GIE_BIT];
        ie_reg  <= pwdata[N_IRQ-1:0];
      end
    end
  end

  // pending latches: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      il_reg <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < N_IRQ; i++) begin
        if (irq_s2[i]) begin
          il_reg[i] <= 1'b1;
        end else if (wr && hit(paddr, IRQ_PENDING_OFF) && !pwdata[i]) begin
          il_reg[i] <= 1'b0;
        end
      end
      if (wr && hit(paddr, SYSTEM_CONTROL_TWO_OFF) && state_reg == ST_RUN &&
          pwdata[TG_HALT_BIT] && !pwdata[CPU_HALT_BIT] && !wdt_s2 && tbt_en_reg) begin
        il_reg[TBT_IRQ_BIT] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // program counter and vector request
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg   <= '0;
      vec_reg  <= 1'b0;
      vsrc_reg <= '0;
    end else if (clk_en) begin
      vec_reg <= 1'b0;
      if (state_reg == ST_RUN && wr && hit(paddr, SYSTEM_CONTROL_TWO_OFF)) begin
        pc_reg <= entry_pc + PC_W'(PC_ADVANCE);
      end
      if (state_reg == ST_CPU_HALT && |wake_src) begin
        vec_reg  <= gie_reg;
        vsrc_reg <= wake_src;
      end
      if (state_reg == ST_TG_HALT && tbt_fall) begin
        vec_reg  <= product;
        vsrc_reg <= N_IRQ'(1) << TBT_IRQ_BIT;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit(paddr, SYSTEM_CONTROL_TWO_OFF)) begin
      rdata_next[HF_OSC_EN_BIT] = hf_en_reg;
      rdata_next[LF_OSC_EN_BIT] = lf_en_reg;
      rdata_next[CLK_SEL_BIT]   = clk_sel_reg;
      rdata_next[CPU_HALT_BIT]  = cpu_halt_reg;
      rdata_next[TG_HALT_BIT]   = tg_halt_reg;
    end else if (hit(paddr, TIME_BASE_CONTROL_OFF)) begin
      rdata_next[TBT_EN_BIT] = tbt_en_reg;
      rdata_next[2:0]        = tbt_sel_reg;
    end else if (hit(paddr, IRQ_ENABLE_OFF)) begin
      rdata_next[GIE_BIT]     = gie_reg;
      rdata_next[N_IRQ-1:0]   = ie_reg;
    end else if (hit(paddr, IRQ_PENDING_OFF)) begin
      rdata_next[N_IRQ-1:0] = il_reg;
    end else if (hit(paddr, STATUS_OFF)) begin
      rdata_next[1:0] = state_reg;
      rdata_next[2]   = rst_req_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // clock enables and outputs
  // ---------------------------------------------------------------
  assign cpu_clk_en    = state_reg == ST_RUN;
  assign wdt_clk_en    = state_reg == ST_RUN;
  assign periph_clk_en = state_reg != ST_TG_HALT;
  assign tbt_clk_en    = 1'b1;
  assign hold_state    = state_reg != ST_RUN;
  assign resume_pc     = pc_reg;
  assign vector_req    = vec_reg;
  assign vector_src    = vsrc_reg;
  assign hf_osc_on     = hf_en_reg;
  assign lf_osc_on     = lf_en_reg;
  assign main_clk_low  = clk_sel_reg;
  assign sys_reset_req = rst_req_reg;

endmodule // low_power_mode_controller

// [rtl/lpm_pkg.sv]
// Purpose: constants and types for the low-power mode controller
// Assumes: apb register map, 32-bit data
// Notes:   offsets are byte addresses
package lpm_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SYSTEM_CONTROL_TWO_OFF = 8'h00;
  localparam logic [7:0] TIME_BASE_CONTROL_OFF  = 8'h04;
  localparam logic [7:0] IRQ_ENABLE_OFF         = 8'h08;
  localparam logic [7:0] IRQ_PENDING_OFF        = 8'h0C;
  localparam logic [7:0] STATUS_OFF             = 8'h10;

  // ---------------------------------------------------------------
  // system_control_two, time base control and interrupt register field positions
  // ---------------------------------------------------------------
  localparam int HF_OSC_EN_BIT   = 7;
  localparam int LF_OSC_EN_BIT   = 6;
  localparam int CLK_SEL_BIT     = 5;
  localparam int CPU_HALT_BIT    = 4;
  localparam int TG_HALT_BIT     = 2;
  localparam int TBT_EN_BIT      = 7;
  localparam int GIE_BIT         = 31;
  localparam int TBT_IRQ_BIT     = 6;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic       HF_OSC_EN_RST = 1'b1;
  localparam logic       LF_OSC_EN_RST = 1'b0;
  localparam logic       CLK_SEL_RST   = 1'b0;
  localparam logic [2:0] TBT_SEL_RST   = 3'h0;
  localparam logic [2:0] PC_ADVANCE    = 3'h2;
  localparam int         PC_W          = 16;

  typedef enum logic [2:0] {
    MODE_HF_RUN,
    MODE_DUAL_FAST,
    MODE_LF_RUN,
    MODE_LF_DUAL
  } run_mode_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_CPU_HALT,
    ST_TG_HALT
  } halt_state_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            halt_instr;
  } cpu_fetch_t;

endpackage

// [verification/lpm_checker_sva.sv]
// Purpose: concurrent checks on the low-power mode controller ports
// Assumes: zero-wait apb; halt writes taken at the access edge
// Notes:   bound to every controller instance
`timescale 1ns/1ps
module lpm_checker
  import lpm_pkg::*;
#(
  parameter int N_IRQ = 8
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             clk_en,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [N_IRQ-1:0] irq_event,
  input wire logic             wdt_irq,
  input wire logic [PC_W-1:0]  entry_pc,
  input wire logic [PC_W-1:0]  resume_pc,
  input wire logic             cpu_clk_en,
  input wire logic             wdt_clk_en,
  input wire logic             periph_clk_en,
  input wire logic             tbt_clk_en,
  input wire logic             hold_state,
  input wire logic             vector_req,
  input wire logic             hf_osc_on,
  input wire logic             lf_osc_on,
  input wire logic             main_clk_low,
  input wire logic             sys_reset_req
);
  // ---------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------
  logic [1:0] quiet_cnt;
  logic [1:0] wdt_cnt;
  logic       ctl_wr;
  logic       halt_wr;
  assign ctl_wr  = psel && penable && pwrite && clk_en && !hold_state
                   && paddr == SYSTEM_CONTROL_TWO_OFF;
  assign halt_wr = ctl_wr && (pwdata[CPU_HALT_BIT] || pwdata[TG_HALT_BIT]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt <= 2'h0;
      wdt_cnt   <= 2'h0;
    end else begin
      quiet_cnt <= (wdt_irq || irq_event != '0) ? 2'h0 : quiet_cnt + 2'(quiet_cnt != 2'h3);
      wdt_cnt   <= !wdt_irq ? 2'h0 : wdt_cnt + 2'(wdt_cnt != 2'h3);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_gate_pair: assert property (wdt_clk_en == cpu_clk_en)
    else $error("cpu and watchdog clock enables differ");
  a_halt_stops_cpu: assert property (hold_state && $past(hold_state) |-> !cpu_clk_en)
    else $error("cpu clock runs while halted");
  a_periph_tg: assert property (!periph_clk_en |-> hold_state && tbt_clk_en)
    else $error("peripheral clock stopped outside halt");
  a_resume_pc: assert property ($rose(hold_state) |-> resume_pc == $past(entry_pc) + 16'h0002)
    else $error("resume address wrong");
  a_halt_entry: assert property (halt_wr && quiet_cnt == 2'h3 |=> hold_state)
    else $error("halt write did not halt");
  a_wdt_block: assert property (halt_wr && wdt_cnt == 2'h3 |=> !hold_state)
    else $error("halt entered despite watchdog interrupt");
  a_vector_pulse: assert property (vector_req |=> !vector_req)
    else $error("vector request longer than one cycle");
  a_hf_stop: assert property (ctl_wr && !pwdata[HF_OSC_EN_BIT] |=> !hf_osc_on)
    else $error("high oscillator not stopped");
  a_reset_req: assert property ((!hf_osc_on && !main_clk_low) || (!lf_osc_on && main_clk_low)
                                |-> ##[0:1] sys_reset_req)
    else $error("illegal oscillator setting without reset");
  a_freeze_hold: assert property (!clk_en |=> $stable(hold_state))
    else $error("halt state changed while clock enable low");
  c_halt: cover property ($rose(hold_state));
  c_vector: cover property (vector_req);
  c_tg: cover property (!periph_clk_en);
  c_reset_req: cover property (sys_reset_req);
endmodule // lpm_checker

bind low_power_mode_controller lpm_checker #(.N_IRQ(N_IRQ)) lpm_checker_inst (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq_event(irq_event), .wdt_irq(wdt_irq),
  .entry_pc(entry_pc), .resume_pc(resume_pc), .cpu_clk_en(cpu_clk_en),
  .wdt_clk_en(wdt_clk_en), .periph_clk_en(periph_clk_en), .tbt_clk_en(tbt_clk_en),
  .hold_state(hold_state), .vector_req(vector_req), .hf_osc_on(hf_osc_on),
  .lf_osc_on(lf_osc_on), .main_clk_low(main_clk_low), .sys_reset_req(sys_reset_req));

// [verification/test_low_power_mode_controller.sv]
// Purpose: self-checking bench for the low-power mode controller
// Assumes: zero-wait apb slave, tbt select n picks source bit n
// Notes:   register rows first, then halt, wake and clock cases
`timescale 1ns/1ps
module test_low_power_mode_controller;
  import lpm_pkg::*;
  typedef struct { logic [7:0] a; bit w; logic [31:0] d, m, e; } row_t;
  typedef struct { logic [31:0] en, tb, sys, st; logic [7:0] irq, fall, vs; int vec; } case_t;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic        wdt_irq = 0, pready, pslverr, cpu_clk_en, wdt_clk_en, periph_clk_en;
  logic        tbt_clk_en, hold_state, vector_req, hf_osc_on, lf_osc_on, main_clk_low;
  logic        sys_reset_req;
  logic [7:0]  paddr = 0, tbt_sources = 8'hFF, irq_event = 0, vector_src, vsrc;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] entry_pc = 16'h1234, resume_pc;
  int          error_cnt = 0, checks_done = 0, vec_cnt = 0;
  row_t rows [6] = '{'{8'h00, 0, 0, 32'hF4, 32'h80}, '{8'h10, 0, 0, 32'h7, 0},
    '{8'h04, 1, 32'h83, 32'h87, 32'h83}, '{8'h08, 1, 32'h800000FF, 32'h800000FF, 32'h800000FF},
    '{8'h14, 1, 32'hFFFFFFFF, 32'hFFFFFFFF, 0}, '{8'h08, 1, 0, 32'h800000FF, 0}};
  case_t cases [4] = '{'{1, 0, 32'h90, 1, 8'h01, 0, 0, 0}, '{32'h80000002, 0, 32'h90, 1, 8'h02, 0,
    8'h02, 1}, '{0, 32'h83, 32'h84, 2, 0, 8'h08, 0, 0}, '{32'h80000040, 32'h83, 32'h84, 2, 0,
    8'h08, 8'h40, 1}};
  logic [31:0] hb [2] = '{32'h90, 32'h84};
  low_power_mode_controller #(.N_IRQ(8)) low_power_mode_controller_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_event(irq_event), .wdt_irq(wdt_irq), .tbt_sources(tbt_sources),
    .entry_pc(entry_pc), .resume_pc(resume_pc), .cpu_clk_en(cpu_clk_en),
    .wdt_clk_en(wdt_clk_en), .periph_clk_en(periph_clk_en), .tbt_clk_en(tbt_clk_en),
    .hold_state(hold_state), .vector_req(vector_req), .vector_src(vector_src),
    .hf_osc_on(hf_osc_on), .lf_osc_on(lf_osc_on), .main_clk_low(main_clk_low),
    .sys_reset_req(sys_reset_req));
  always #50 pclk = ~pclk;
  always @(negedge pclk) begin
    if (vector_req === 1'b1) begin
      vec_cnt++;
      vsrc = vector_src;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task report_and_stop;
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task xfer(bit w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) error_cnt++;
    q = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task wait_hold(logic v);
    int i;
    i = 0;
    while (hold_state !== v && i < 50) begin
      @(negedge pclk);
      i++;
    end
    chk("hold_state", v, hold_state);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    chk("reset osc", 3'b100, {hf_osc_on, lf_osc_on, main_clk_low});
    chk("reset run", 2'b10, {cpu_clk_en, hold_state});
    presetn <= 1;
    foreach (rows[k]) begin
      if (rows[k].w) xfer(1, rows[k].a, rows[k].d, rd);
      xfer(0, rows[k].a, 0, rd);
      chk("register row", rows[k].e, rd & rows[k].m);
    end
    foreach (cases[k]) begin
      xfer(1, IRQ_ENABLE_OFF, cases[k].en, rd);
      xfer(1, TIME_BASE_CONTROL_OFF, cases[k].tb, rd);
      xfer(1, SYSTEM_CONTROL_TWO_OFF, cases[k].sys, rd);
      repeat (2) @(negedge pclk);
      chk("halted", 1, hold_state);
      chk("periph_clk_en", cases[k].st == 1, periph_clk_en);
      chk("resume_pc", 16'h1236, resume_pc);
      xfer(0, STATUS_OFF, 0, rd);
      chk("status", cases[k].st, rd & 32'h3);
      vec_cnt = 0;
      irq_event <= cases[k].irq;
      tbt_sources <= ~cases[k].fall;
      wait_hold(0);
      @(negedge pclk);
      chk("vectors", cases[k].vec, vec_cnt);
      if (cases[k].vec == 1) chk("vector_src", cases[k].vs, vsrc);
      xfer(0, SYSTEM_CONTROL_TWO_OFF, 0, rd);
      chk("halt bits", 32'h80, rd & 32'hF4);
      xfer(0, IRQ_PENDING_OFF, 0, rd);
      if (k == 2) chk("time base latch", 32'h40, rd & 32'h40);
      irq_event <= 0;
      tbt_sources <= 8'hFF;
      repeat (4) @(posedge pclk);
      xfer(1, IRQ_PENDING_OFF, 0, rd);
    end
    foreach (hb[k]) begin
      wdt_irq <= 1;
      repeat (4) @(posedge pclk);
      xfer(1, SYSTEM_CONTROL_TWO_OFF, hb[k], rd);
      repeat (2) @(negedge pclk);
      chk("watchdog blocks halt", 0, hold_state);
      wdt_irq <= 0;
      repeat (4) @(posedge pclk);
    end
    clk_en <= 0;
    xfer(1, SYSTEM_CONTROL_TWO_OFF, 32'h90, rd);
    repeat (2) @(negedge pclk);
    chk("frozen hold_state", 0, hold_state);
    @(posedge pclk);
    clk_en <= 1;
    xfer(1, IRQ_ENABLE_OFF, 1, rd);
    xfer(1, SYSTEM_CONTROL_TWO_OFF, 32'hE0, rd);
    xfer(1, SYSTEM_CONTROL_TWO_OFF, 32'h60, rd);
    @(negedge pclk);
    chk("slow osc", 4'b0110, {hf_osc_on, lf_osc_on, main_clk_low, sys_reset_req});
    xfer(1, SYSTEM_CONTROL_TWO_OFF, 32'h70, rd);
    wait_hold(1);
    irq_event <= 1;
    wait_hold(0);
    chk("prior mode", 1, main_clk_low);
    irq_event <= 0;
    xfer(1, SYSTEM_CONTROL_TWO_OFF, 32'h20, rd);
    repeat (2) @(negedge pclk);
    chk("sys_reset_req", 1, sys_reset_req);
    xfer(1, IRQ_ENABLE_OFF, 0, rd);
    xfer(1, IRQ_PENDING_OFF, 0, rd);
    xfer(1, SYSTEM_CONTROL_TWO_OFF, 32'h64, rd);
    wait_hold(1);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(negedge pclk);
    chk("reset ends halt", 4'h5, {hold_state, hf_osc_on, main_clk_low, cpu_clk_en});
    @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    report_and_stop;
  end
  initial begin
    #300000;
    error_cnt++;
    report_and_stop;
  end
endmodule // test_low_power_mode_controller
